//--- src/osf_pkg.sv
// Constants, types and decoding shared by the start-up sequencer
package osf_pkg;
    // Command codes of the sequencing registers
    localparam logic [7:0] CODE_PG_ON = 8'h5e;
    localparam logic [7:0] CODE_PG_OFF = 8'h5f;
    localparam logic [7:0] CODE_DELAY = 8'h60;
    localparam logic [7:0] CODE_RISE = 8'h61;
    localparam logic [7:0] CODE_LIMIT = 8'h62;
    localparam logic [7:0] CODE_ACTION = 8'h63;
    localparam int NUM_REGS = 6;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Millisecond tick derived from the 8 ns system clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Fields of the fault action byte
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int UNITS_HI = 2;
    localparam int UNITS_LO = 0;
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_CONTINUE = 2'h1;
    localparam logic [1:0] RESP_DISABLE = 2'h2;
    localparam logic [1:0] RESP_LATCH = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    typedef enum logic [7:0] {
        ST_OFF = 8'h01,
        ST_DELAY = 8'h02,
        ST_RAMP = 8'h04,
        ST_SETTLE = 8'h08,
        ST_ON = 8'h10,
        ST_FAULT_RUN = 8'h20,
        ST_WAIT_RETRY = 8'h40,
        ST_LATCHED = 8'h80
    } osf_state_type;

    // Decoded timing settings, held in milliseconds, and the fault action byte
    typedef struct packed {
        logic [15:0] delay_ms;
        logic [15:0] rise_ms;
        logic [15:0] limit_ms;
        logic [7:0] action;
    } osf_cfg_type;

    // Linear word to whole milliseconds; negatives give zero, overflow saturates
    function automatic logic [15:0] osf_linear_to_ms(input logic [15:0] word);
        logic [4:0] expo;
        logic [31:0] wide;
        expo = word[15:11];
        wide = {21'h000000, word[10:0]};
        if (word[10]) begin
            return 16'h0000;
        end
        if (!expo[4]) begin
            wide = wide << expo[3:0];
        end else begin
            wide = wide >> (5'h00 - expo);
        end
        return (wide[31:16] != 16'h0000) ? 16'hffff : wide[15:0];
    endfunction
endpackage

//--- src/osf_sequencer.sv
// Turn-on sequencing, power-good and start-up timeout fault response
`timescale 1ns/1ns
`default_nettype none
module osf_sequencer
    import osf_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Decoded command port from the management bus
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] wr_data,
    output logic [15:0] rd_data,
    output logic rd_valid,
    // Control pin and fault housekeeping
    input wire logic enable_pin,
    input wire logic clear_fault,
    input wire logic other_fault_off,
    input wire logic [7:0] vout_fault_unit_ms,
    input wire logic pg_pin_enable,
    // Output voltage measurement and undervoltage limit
    input wire logic [15:0] vout_level,
    input wire logic [15:0] uv_fault_level,
    // Outputs to the power stage and status
    output logic out_enable,
    output logic ramp_active,
    output logic power_good,
    output logic power_good_pin,
    output logic pg_status,
    output logic start_fault,
    output logic [2:0] retry_count,
    output osf_state_type seq_state
);
    logic [15:0] raw [NUM_REGS];
    logic [15:0] next_raw [NUM_REGS];
    osf_cfg_type cfg, next_cfg;
    logic [15:0] next_rd_data;
    logic next_rd_valid;
    logic [31:0] tick_cnt, next_tick_cnt;
    logic ms_tick;
    logic en_meta, en_sync;
    osf_state_type state, next_state;
    logic [23:0] cnt, next_cnt;
    logic [15:0] tmo, next_tmo;
    logic [2:0] tries, next_tries;
    logic fault, next_fault;
    logic pg, next_pg, pg_st, next_pg_st;
    logic reached, timeout_hit, clr_any, retry_left;
    logic [1:0] resp;
    logic [2:0] retry_set;
    logic [23:0] fault_wait;
    logic [7:0] wr_idx, rd_idx;
    assign wr_idx = cmd_code - CODE_PG_ON;
    assign rd_idx = cmd_code - CODE_PG_ON;
    // Register writes; timings decoded once here, not in the sequencer path
    always_comb begin
        next_raw = raw;
        next_cfg = cfg;
        if (wr_en && cmd_code >= CODE_PG_ON && cmd_code <= CODE_ACTION) begin
            next_raw[wr_idx[2:0]] = (cmd_code == CODE_ACTION) ? {8'h00, wr_data[7:0]} : wr_data;
            unique case (cmd_code)
                CODE_DELAY: next_cfg.delay_ms = osf_linear_to_ms(wr_data);
                CODE_RISE: next_cfg.rise_ms = osf_linear_to_ms(wr_data);
                CODE_LIMIT: next_cfg.limit_ms = osf_linear_to_ms(wr_data);
                CODE_ACTION: next_cfg.action = wr_data[7:0];
                default: next_cfg = cfg;
            endcase
        end
        next_rd_valid = rd_en;
        next_rd_data = rd_data;
        if (rd_en) begin
            // Unknown codes read as zero
            next_rd_data = (rd_idx < 8'(NUM_REGS)) ? raw[rd_idx[2:0]] : 16'h0000;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            raw <= '{default: REG_RESET};
            cfg <= '0;
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            raw <= next_raw;
            cfg <= next_cfg;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    // Common millisecond tick
    always_comb begin
        next_tick_cnt = (tick_cnt >= 32'(TICK_LEN - 1)) ? 32'h00000000 : tick_cnt + 32'h1;
    end
    assign ms_tick = (tick_cnt == 32'(TICK_LEN - 1));
    // Tick counter; control pin crosses in through two flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= 32'h00000000;
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            en_meta <= enable_pin;
            en_sync <= en_meta;
        end
    end
    assign resp = cfg.action[RESP_HI:RESP_LO];
    assign retry_set = cfg.action[RETRY_HI:RETRY_LO];
    // Fault wait uses the output voltage fault unit
    assign fault_wait = 24'(vout_fault_unit_ms) << cfg.action[UNITS_HI:UNITS_LO];
    assign reached = (vout_level >= uv_fault_level);
    assign timeout_hit = (state == ST_RAMP || state == ST_SETTLE) && cfg.limit_ms != 16'h0000
        && tmo >= cfg.limit_ms && !reached;
    assign retry_left = (retry_set == RETRY_FOREVER) || (tries < retry_set);
    assign clr_any = clear_fault || !en_sync;
    // Sequencer next state
    always_comb begin
        next_state = state;
        next_cnt = (ms_tick && cnt != 24'h000000) ? cnt - 24'h1 : cnt;
        next_tmo = (ms_tick && tmo != 16'hffff) ? tmo + 16'h1 : tmo;
        next_tries = tries;
        // Set wins over a clear in the same cycle
        next_fault = (fault && !clr_any) || timeout_hit;
        unique case (state)
            ST_OFF: begin
                if (en_sync) begin
                    next_state = ST_DELAY;
                    next_cnt = 24'(cfg.delay_ms);
                end
            end
            ST_DELAY: begin
                if (cnt == 24'h000000) begin
                    next_state = ST_RAMP;
                    next_cnt = 24'(cfg.rise_ms);
                    next_tmo = 16'h0000;
                end
            end
            ST_RAMP, ST_SETTLE: begin
                if (timeout_hit) begin
                    unique case (resp)
                        RESP_IGNORE: next_state = ST_ON;
                        RESP_CONTINUE: begin
                            next_state = ST_FAULT_RUN;
                            next_cnt = fault_wait;
                        end
                        RESP_DISABLE: begin
                            next_state = retry_left ? ST_WAIT_RETRY : ST_LATCHED;
                            next_cnt = fault_wait;
                        end
                        RESP_LATCH: next_state = ST_LATCHED;
                    endcase
                end else if (state == ST_RAMP && cnt == 24'h000000) begin
                    next_state = ST_SETTLE;
                end else if (state == ST_SETTLE && reached) begin
                    next_state = ST_ON;
                end
            end
            ST_ON: next_state = ST_ON;
            ST_FAULT_RUN: begin
                if (cnt == 24'h000000) begin
                    if (reached) begin
                        next_state = ST_ON;
                    end else begin
                        next_state = retry_left ? ST_WAIT_RETRY : ST_LATCHED;
                        next_cnt = fault_wait;
                    end
                end
            end
            ST_WAIT_RETRY: begin
                if (cnt == 24'h000000) begin
                    next_state = ST_DELAY;
                    next_cnt = 24'(cfg.delay_ms);
                    next_tries = (tries == 3'h7) ? tries : tries + 3'h1;
                end
            end
            ST_LATCHED: begin
                if (clear_fault) begin
                    next_state = ST_OFF;
                end
            end
        endcase
        // Off command wins; another fault stops even endless retry
        if (!en_sync) begin
            next_state = ST_OFF;
        end else if (other_fault_off) begin
            next_state = ST_LATCHED;
        end
        if (clr_any) begin
            next_tries = 3'h0;
        end
    end
    // Power-good with hysteresis between the two thresholds
    always_comb begin
        next_pg = pg;
        next_pg_st = pg_st && !clear_fault;
        if (!out_enable) begin
            next_pg = 1'b0;
        end else if (!pg && vout_level >= raw[0]) begin
            next_pg = 1'b1;
        end else if (pg && vout_level < raw[1]) begin
            next_pg = 1'b0;
        end
        if (out_enable && vout_level < raw[1]) begin
            next_pg_st = 1'b1;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_OFF;
            cnt <= 24'h000000;
            tmo <= 16'h0000;
            tries <= 3'h0;
            fault <= 1'b0;
            pg <= 1'b0;
            pg_st <= 1'b0;
            out_enable <= 1'b0;
            ramp_active <= 1'b0;
            power_good_pin <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            tmo <= next_tmo;
            tries <= next_tries;
            fault <= next_fault;
            pg <= next_pg;
            pg_st <= next_pg_st;
            // Output is live from ramp start until a disabling state
            out_enable <= (next_state == ST_RAMP || next_state == ST_SETTLE
                || next_state == ST_ON || next_state == ST_FAULT_RUN);
            ramp_active <= (next_state == ST_RAMP);
            power_good_pin <= next_pg && pg_pin_enable;
        end
    end
    assign power_good = pg;
    assign pg_status = pg_st;
    assign start_fault = fault;
    assign retry_count = tries;
    assign seq_state = state;
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_pg_rise;
        out_enable && !pg && vout_level >= raw[0];
    endsequence
    sequence s_pg_fall;
        out_enable && pg && vout_level < raw[1];
    endsequence
    a_pg_assert: assert property (s_pg_rise |=> pg)
        else $error("power-good not asserted at threshold");
    a_pg_release: assert property (s_pg_fall |=> !pg && pg_st)
        else $error("power-good not released or status not set");
    a_delay_done: assert property (state == ST_DELAY && cnt == 24'h000000 && en_sync
        && !other_fault_off |=> state == ST_RAMP && cnt == 24'($past(cfg.rise_ms)))
        else $error("delay end did not start ramp");
    a_ramp_output: assert property (state == ST_RAMP |-> out_enable && ramp_active)
        else $error("ramp without output enabled");
    a_timeout_flag: assert property (timeout_hit |=> fault)
        else $error("timeout did not raise fault");
    a_no_limit: assert property (cfg.limit_ms == 16'h0000 && !fault |=> !fault)
        else $error("timeout with zero limit");
    a_ignore_run: assert property (timeout_hit && resp == RESP_IGNORE && en_sync
        && !other_fault_off |=> state == ST_ON && out_enable)
        else $error("ignored fault interrupted output");
    a_disable_now: assert property (timeout_hit && resp == RESP_DISABLE |=> !out_enable)
        else $error("disable response left output on");
    a_latch_hold: assert property (state == ST_LATCHED && en_sync && !clear_fault
        |=> state == ST_LATCHED && !out_enable)
        else $error("latched fault released without clear");
    a_no_retry: assert property (timeout_hit && resp == RESP_DISABLE && retry_set == RETRY_NONE
        && en_sync && !other_fault_off |=> state == ST_LATCHED)
        else $error("retry attempted with retry field zero");
endmodule
`default_nettype wire

//--- test/osf_host_model.sv
// Host controller model that issues register commands to the sequencer
`timescale 1ns/1ns
`default_nettype none
module osf_host_model (
    // Clock
    input wire logic clk_sys,
    // Command port toward the sequencer
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] cmd_code,
    output logic [15:0] wr_data,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    // Idle bus state at time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        cmd_code = 8'h00;
        wr_data = 16'h0000;
    end

    // One write; the strobe spans falling edge to falling edge and is taken at the rising edge between
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk_sys);
        wr_en = 1'b1;
        cmd_code = code;
        wr_data = data;
        @(negedge clk_sys);
        wr_en = 1'b0;
        // Released lines carry the inverse so stale values never look valid
        cmd_code = ~code;
        wr_data = ~data;
    endtask

    // One read; the answer stands one cycle, so it is sampled mid-cycle
    task automatic rd(input logic [7:0] code, output logic [15:0] data);
        @(negedge clk_sys);
        rd_en = 1'b1;
        cmd_code = code;
        @(negedge clk_sys);
        rd_en = 1'b0;
        cmd_code = ~code;
        data = rd_valid ? rd_data : 16'hxxxx;
    endtask
endmodule
`default_nettype wire

//--- test/tb_osf_sequencer.sv
// Self-checking bench for the start-up sequencer and its fault response
`timescale 1ns/1ns
`default_nettype none
module tb_osf_sequencer;
    import osf_pkg::*;
    localparam int TL = 4;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic wr_en, rd_en, rd_valid, out_enable, ramp_active, power_good;
    logic power_good_pin, pg_status, start_fault;
    logic [7:0] cmd_code;
    logic [15:0] wr_data, rd_data, v;
    logic [2:0] retry_count;
    osf_state_type seq_state;
    logic enable_pin = 1'b0;
    logic clear_fault = 1'b0;
    logic other_fault_off = 1'b0;
    logic [7:0] vout_fault_unit_ms = 8'h01;
    logic pg_pin_enable = 1'b1;
    logic [15:0] vout_level = 16'h0000;
    logic [15:0] uv_fault_level = 16'h005a;
    int mismatches = 0;
    int comparisons = 0;
    int n;
    logic [7:0] codes [6] = '{8'h5e, 8'h5f, 8'h60, 8'h61, 8'h62, 8'h63};

    // Short tick keeps millisecond waits to a few cycles
    osf_sequencer #(.TICK_LEN(TL)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
        .wr_en(wr_en), .rd_en(rd_en), .cmd_code(cmd_code), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid), .enable_pin(enable_pin),
        .clear_fault(clear_fault), .other_fault_off(other_fault_off),
        .vout_fault_unit_ms(vout_fault_unit_ms), .pg_pin_enable(pg_pin_enable),
        .vout_level(vout_level), .uv_fault_level(uv_fault_level),
        .out_enable(out_enable), .ramp_active(ramp_active), .power_good(power_good),
        .power_good_pin(power_good_pin), .pg_status(pg_status),
        .start_fault(start_fault), .retry_count(retry_count), .seq_state(seq_state));
    osf_host_model host_u (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en),
        .cmd_code(cmd_code), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

    always #4 clk_sys = ~clk_sys;

    task automatic stop_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Bounded wait for a state, then compare it
    task automatic wait_st(input osf_state_type st, input int lim);
        int k;
        k = 0;
        while (seq_state !== st && k < lim) begin
            @(negedge clk_sys);
            k++;
        end
        chk("seq_state", {8'h00, st}, {8'h00, seq_state});
    endtask

    // Drop the pin (off clears faults), program timing, then turn on
    task automatic start(input logic [15:0] dly, input logic [15:0] rise,
            input logic [15:0] lim, input logic [7:0] act);
        enable_pin = 1'b0;
        repeat (4) @(negedge clk_sys);
        host_u.wr(8'h60, dly);
        host_u.wr(8'h61, rise);
        host_u.wr(8'h62, lim);
        host_u.wr(8'h63, {8'h00, act});
        enable_pin = 1'b1;
    endtask

    // Watchdog sized well above the expected run length
    initial begin
        #(20000 * 8);
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (3) @(negedge clk_sys);
        arst_n = 1'b1;
        // Reset values, readback and the unmapped code
        for (int i = 0; i < 6; i++) begin
            host_u.rd(codes[i], v);
            chk("reg_reset", REG_RESET, v);
            host_u.wr(codes[i], 16'ha5c3 ^ 16'(i));
            host_u.rd(codes[i], v);
            chk("reg_rw", (i == 5) ? 16'h00c6 : (16'ha5c3 ^ 16'(i)), v);
        end
        host_u.wr(8'h64, 16'h1234);
        host_u.rd(8'h64, v);
        chk("unmapped", 16'h0000, v);
        host_u.wr(8'h5e, 16'h0064);
        host_u.wr(8'h5f, 16'h0050);
        // Turn-on delay then rise ramp, counted in cycles
        vout_level = 16'h0064;
        start(16'h0003, 16'h0002, 16'h0000, 8'h00);
        wait_st(ST_DELAY, 6);
        n = 0;
        while (!out_enable && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        chk("delay_cycles", 16'h0001, {15'h0000, n >= 2 * TL && n <= 3 * TL + 2});
        chk("ramp_active", 16'h0001, {15'h0000, ramp_active});
        n = 0;
        while (ramp_active && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        chk("rise_cycles", 16'h0001, {15'h0000, n >= TL && n <= 2 * TL + 2});
        wait_st(ST_ON, 6);
        // Power-good hysteresis and pin gating
        repeat (2) @(negedge clk_sys);
        chk("power_good", 16'h0001, {15'h0000, power_good});
        chk("pg_pin", 16'h0001, {15'h0000, power_good_pin});
        vout_level = 16'h005a;
        repeat (3) @(negedge clk_sys);
        chk("pg_held", 16'h0001, {15'h0000, power_good});
        pg_pin_enable = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("pg_pin_off", 16'h0000, {15'h0000, power_good_pin});
        pg_pin_enable = 1'b1;
        vout_level = 16'h0046;
        repeat (3) @(negedge clk_sys);
        chk("pg_low", 16'h0000, {15'h0000, power_good});
        chk("pg_status", 16'h0001, {15'h0000, pg_status});
        vout_level = 16'h0064;
        clear_fault = 1'b1;
        @(negedge clk_sys);
        clear_fault = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("pg_status_clr", 16'h0000, {15'h0000, pg_status});
        // Output never reaches the limit from here on
        vout_level = 16'h0000;
        start(16'h0000, 16'h0001, 16'h0000, 8'h80);
        repeat (100) @(negedge clk_sys);
        chk("no_limit", 16'h0001, {15'h0000, out_enable && !start_fault});
        start(16'h0000, 16'h0001, 16'h0002, 8'h00);
        repeat (40) @(negedge clk_sys);
        chk("ignore_fault", 16'h0001, {15'h0000, start_fault});
        chk("ignore_on", {8'h00, ST_ON}, {8'h00, seq_state});
        chk("ignore_out", 16'h0001, {15'h0000, out_enable});
        // Keep running for four units of two ms each, then no retry
        vout_fault_unit_ms = 8'h02;
        start(16'h0000, 16'h0001, 16'h0002, 8'h42);
        wait_st(ST_FAULT_RUN, 40);
        n = 0;
        while (seq_state === ST_FAULT_RUN && out_enable && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        chk("run_cycles", 16'h0001, {15'h0000, n >= 7 * TL && n <= 9 * TL + 2});
        wait_st(ST_LATCHED, 4);
        vout_fault_unit_ms = 8'h01;
        // Every finite retry count, each attempt a full start sequence
        for (int r = 0; r < 7; r++) begin
            start(16'h0000, 16'h0001, 16'h0002, {2'b10, 3'(r), 3'b000});
            wait_st(ST_LATCHED, 400);
            chk("retry_count", 16'(r), {13'h0000, retry_count});
            chk("latched_out", 16'h0000, {15'h0000, out_enable});
        end
        // Endless retry never latches on its own; another fault stops it
        start(16'h0000, 16'h0001, 16'h0002, 8'hb8);
        repeat (400) @(negedge clk_sys);
        chk("endless", 16'h0001, {15'h0000, seq_state !== ST_LATCHED});
        other_fault_off = 1'b1;
        wait_st(ST_LATCHED, 8);
        other_fault_off = 1'b0;
        // Clear pulse drops the latch, the fault flag and the attempt count
        clear_fault = 1'b1;
        @(negedge clk_sys);
        clear_fault = 1'b0;
        chk("clear_off", {8'h00, ST_OFF}, {8'h00, seq_state});
        chk("retry_clear", 16'h0000, {12'h000, start_fault, retry_count});
        // Latch-off response cleared by the clear pulse, then the pin dropped to off
        start(16'h0000, 16'h0001, 16'h0002, 8'hc0);
        wait_st(ST_LATCHED, 40);
        repeat (20) @(negedge clk_sys);
        chk("latch_out", 16'h0000, {15'h0000, out_enable});
        clear_fault = 1'b1;
        @(negedge clk_sys);
        clear_fault = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("cleared", 16'h0000, {12'h000, start_fault, retry_count});
        enable_pin = 1'b0;
        wait_st(ST_OFF, 8);
        stop_test();
    end
endmodule
`default_nettype wire
